// >>> design/cffc_pkg.sv
package cffc_pkg;

    // Register word indexes; the byte address is four times the index
    localparam logic [7:0] TX_FRONTEND_IDX     = 8'h65;
    localparam logic [7:0] RX_FRONTEND_IDX     = 8'h66;
    localparam logic [7:0] SAMPLE_FORMAT_IDX   = 8'h67;
    localparam logic [7:0] RX_SOURCE_IDX       = 8'h68;
    localparam logic [7:0] MISC_CTRL_IDX       = 8'h70;
    localparam logic [7:0] VOICE_DATA_IDX      = 8'h71;

    // Reset values
    localparam logic [7:0] TX_FRONTEND_RST     = 8'h00;
    localparam logic [7:0] RX_FRONTEND_RST     = 8'h00;
    localparam logic [7:0] SAMPLE_FORMAT_RST   = 8'h00;
    localparam logic [7:0] RX_SOURCE_RST       = 8'h00;
    localparam logic [7:0] MISC_CTRL_RST       = 8'h00;

    // Field positions
    localparam int INPUT_GAIN_LSB      = 4;
    localparam int MON_FLOOR_BIT       = 2;
    localparam int EAR_GAIN_LSB        = 4;
    localparam int SPK_GAIN_LSB        = 0;
    localparam int RX_FMT2_LSB         = 6;
    localparam int TX_FMT2_LSB         = 4;
    localparam int RX_FMT1_LSB         = 2;
    localparam int TX_FMT1_LSB         = 0;
    localparam int RX_SRC_LSB          = 6;
    localparam int CMON_EN_BIT         = 0;
    localparam int RING_SPK_BIT        = 1;

    // Gain codes
    localparam logic [3:0] GAIN_OFF        = 4'h0;
    localparam logic [3:0] GAIN_BYPASS     = 4'hf;
    localparam logic [3:0] IN_GAIN_MAX     = 4'h8;
    localparam logic [3:0] EAR_GAIN_MAX    = 4'h9;
    localparam logic [3:0] SPK_GAIN_MAX    = 4'hc;
    localparam logic [3:0] SPK_RING_MAX    = 4'he;
    localparam logic [3:0] SPK_FLOOR_9P5   = 4'h8;
    localparam logic [3:0] SPK_FLOOR_21P5  = 4'hc;

    typedef enum logic [1:0] {
        CFFC_FMT_ALAW = 2'h0,
        CFFC_FMT_ULAW = 2'h1,
        CFFC_FMT_LIN8 = 2'h2,
        CFFC_FMT_LIN16 = 2'h3
    } cffc_fmt_e;

    typedef enum logic [1:0] {
        CFFC_SRC_IDLE = 2'h0,
        CFFC_SRC_CH1  = 2'h1,
        CFFC_SRC_CH2  = 2'h2,
        CFFC_SRC_SUM  = 2'h3
    } cffc_src_e;

    typedef enum logic [2:0] {
        CFFC_IN_PAIR1 = 3'b001,
        CFFC_IN_PAIR2 = 3'b010,
        CFFC_IN_AUX   = 3'b100
    } cffc_in_e;

    // Analog front-end control bundle
    typedef struct packed {
        logic       front_amp_on;
        logic       input_prefilter_on;
        logic [3:0] input_gain_sel;
        logic [2:0] input_route;
        logic       earpiece_amp_on;
        logic [3:0] earpiece_gain_sel;
        logic       speaker_amp_on;
        logic [3:0] speaker_gain_sel;
        logic       ring_to_speaker;
        logic       bypass_test;
    } cffc_afe_s;

    // Datapath format bundle
    typedef struct packed {
        cffc_fmt_e rx_fmt_ch1;
        cffc_fmt_e rx_fmt_ch2;
        cffc_fmt_e tx_fmt_ch1;
        cffc_fmt_e tx_fmt_ch2;
        cffc_src_e rx_src;
    } cffc_fmt_s;

endpackage : cffc_pkg

// >>> design/cffc_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - Input gain 0000 powers down amp and prefilter; 0001-1000 give 0 to 42 dB.
// - Gain code 1111 is a test bypass; software must not use it.
// - Monitor floor bit sets lowest speaker gain: -9.5 dB or -21.5 dB.
// - Input source bits 1:0 pick pair one, pair two, aux; 11 unused.
// - Earpiece gain 0000 off; 0001 is 2.5 dB; then -0.5 to -21.5 dB.
// - Speaker gain 0000 off; 0001-1100 give 11.5 down to -21.5 dB.
// - Speaker codes 1101 and 1110 only valid with ring to speaker.
// - Receive format at bits 7:6 channel two, 3:2 channel one.
// - Transmit format at bits 5:4 channel two, 1:0 channel one.
// - Linear modes: high register gets sample 15:8; low register gets 7:0 in 16-bit mode, zero in 8-bit mode.
// - Receive source bits 7:6: idle, channel one, channel two, sum.
// - Controlled monitoring fixes speaker codes 0001-1100 at the chosen floor; ring-only and bypass codes pass as written.
// - Ring to speaker drives the square ringing onto speaker pins.
module cffc_regs (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic [15:0]         tx_sample_ch1,
    input  wire logic                ring_square,
    output cffc_pkg::cffc_afe_s      afe_ctrl,
    output cffc_pkg::cffc_fmt_s      fmt_ctrl,
    output logic                     speaker_drive_ring,
    output logic                     speaker_ring_level
);

    // Assertion clock and reset
    default clocking cffc_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Configuration registers
    logic [7:0] tx_frontend_cfg;
    logic [7:0] rx_frontend_cfg;
    logic [7:0] sample_format_cfg;
    logic [7:0] rx_source_cfg;
    logic [7:0] misc_ctrl;
    logic [7:0] voice_reg_high;
    logic [7:0] voice_reg_low;

    // Data phase bookkeeping
    logic       dp_write;
    logic       dp_read;
    logic [7:0] dp_index;

    // Address phase decode
    wire        addr_valid = hsel && hready && htrans[1];
    wire [7:0]  addr_index = haddr[9:2];
    wire        wr_tx      = dp_write && (dp_index == cffc_pkg::TX_FRONTEND_IDX);
    wire        wr_rx      = dp_write && (dp_index == cffc_pkg::RX_FRONTEND_IDX);
    wire        wr_fmt     = dp_write && (dp_index == cffc_pkg::SAMPLE_FORMAT_IDX);
    wire        wr_src     = dp_write && (dp_index == cffc_pkg::RX_SOURCE_IDX);
    wire        wr_misc    = dp_write && (dp_index == cffc_pkg::MISC_CTRL_IDX);
    wire [7:0]  wdata      = hwdata[7:0];

    // Capture the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_index <= 8'h00;
        end else begin
            dp_write <= addr_valid && hwrite;
            dp_read  <= addr_valid && !hwrite;
            dp_index <= addr_valid ? addr_index : dp_index;
        end
    end

    // Register writes; codes stored as written, except misc_ctrl keeps only bits 1:0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_frontend_cfg   <= cffc_pkg::TX_FRONTEND_RST;
            rx_frontend_cfg   <= cffc_pkg::RX_FRONTEND_RST;
            sample_format_cfg <= cffc_pkg::SAMPLE_FORMAT_RST;
            rx_source_cfg     <= cffc_pkg::RX_SOURCE_RST;
            misc_ctrl         <= cffc_pkg::MISC_CTRL_RST;
        end else begin
            if (wr_tx) tx_frontend_cfg <= wdata;
            if (wr_rx) rx_frontend_cfg <= wdata;
            if (wr_fmt) sample_format_cfg <= wdata;
            if (wr_src) rx_source_cfg <= wdata;
            if (wr_misc) misc_ctrl <= {6'h00, wdata[1:0]};
        end
    end

    // Read mux, unmapped words read zero
    logic [7:0] rd_byte;
    always_comb begin
        if (dp_index == cffc_pkg::TX_FRONTEND_IDX) begin
            rd_byte = tx_frontend_cfg;
        end else if (dp_index == cffc_pkg::RX_FRONTEND_IDX) begin
            rd_byte = rx_frontend_cfg;
        end else if (dp_index == cffc_pkg::SAMPLE_FORMAT_IDX) begin
            rd_byte = sample_format_cfg;
        end else if (dp_index == cffc_pkg::RX_SOURCE_IDX) begin
            rd_byte = rx_source_cfg;
        end else if (dp_index == cffc_pkg::MISC_CTRL_IDX) begin
            rd_byte = misc_ctrl;
        end else if (dp_index == cffc_pkg::VOICE_DATA_IDX) begin
            rd_byte = voice_reg_high;
        end else begin
            rd_byte = 8'h00;
        end
    end

    wire [31:0] rd_word = (dp_index == cffc_pkg::VOICE_DATA_IDX) ?
                          {16'h0000, voice_reg_high, voice_reg_low} : {24'h000000, rd_byte};

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = dp_read ? rd_word : 32'h0000_0000;

    // Field extraction
    wire [3:0] in_code   = tx_frontend_cfg[cffc_pkg::INPUT_GAIN_LSB +: 4];
    wire       mon_floor = tx_frontend_cfg[cffc_pkg::MON_FLOOR_BIT];
    wire [1:0] in_src    = tx_frontend_cfg[1:0];
    wire [3:0] ear_code  = rx_frontend_cfg[cffc_pkg::EAR_GAIN_LSB +: 4];
    wire [3:0] spk_code  = rx_frontend_cfg[cffc_pkg::SPK_GAIN_LSB +: 4];
    wire       cmon_en   = misc_ctrl[cffc_pkg::CMON_EN_BIT];
    wire       ring_spk  = misc_ctrl[cffc_pkg::RING_SPK_BIT];

    // Gain code validity; undocumented codes act as power-down
    wire in_ok  = (in_code != cffc_pkg::GAIN_OFF) &&
                  (in_code <= cffc_pkg::IN_GAIN_MAX);
    wire ear_ok = (ear_code != cffc_pkg::GAIN_OFF) &&
                  (ear_code <= cffc_pkg::EAR_GAIN_MAX);
    wire spk_nrm = (spk_code != cffc_pkg::GAIN_OFF) &&
                   (spk_code <= cffc_pkg::SPK_GAIN_MAX);
    wire spk_rng = ring_spk && (spk_code > cffc_pkg::SPK_GAIN_MAX) &&
                   (spk_code <= cffc_pkg::SPK_RING_MAX);
    wire in_byp  = (in_code == cffc_pkg::GAIN_BYPASS);
    wire ear_byp = (ear_code == cffc_pkg::GAIN_BYPASS);
    wire spk_byp = (spk_code == cffc_pkg::GAIN_BYPASS);

    // Controlled monitoring pins speaker codes 0001-1100 at the floor; ring-only and bypass codes pass
    wire [3:0] spk_floor = mon_floor ? cffc_pkg::SPK_FLOOR_21P5 : cffc_pkg::SPK_FLOOR_9P5;
    wire       spk_on    = spk_nrm || spk_rng || spk_byp;
    wire [3:0] spk_eff   = (cmon_en && spk_nrm) ? spk_floor : spk_code;

    // Input routing
    logic [2:0] in_route;
    always_comb begin
        case (in_src)
            2'b00:   in_route = cffc_pkg::CFFC_IN_PAIR1;
            2'b01:   in_route = cffc_pkg::CFFC_IN_PAIR2;
            2'b10:   in_route = cffc_pkg::CFFC_IN_AUX;
            default: in_route = 3'b000;
        endcase
    end

    // Decoded front-end controls, registered
    cffc_pkg::cffc_afe_s next_afe;
    always_comb begin
        next_afe                    = '0;
        next_afe.front_amp_on       = in_ok || in_byp;
        next_afe.input_prefilter_on = in_ok || in_byp;
        next_afe.input_gain_sel     = (in_ok || in_byp) ? in_code : cffc_pkg::GAIN_OFF;
        next_afe.input_route        = in_route;
        next_afe.earpiece_amp_on    = ear_ok || ear_byp;
        next_afe.earpiece_gain_sel  = (ear_ok || ear_byp) ? ear_code : cffc_pkg::GAIN_OFF;
        next_afe.speaker_amp_on     = spk_on;
        next_afe.speaker_gain_sel   = spk_on ? spk_eff : cffc_pkg::GAIN_OFF;
        next_afe.ring_to_speaker    = ring_spk;
        next_afe.bypass_test        = in_byp || ear_byp || spk_byp;
    end

    // Format and source decode
    wire [1:0] rx2_bits = sample_format_cfg[cffc_pkg::RX_FMT2_LSB +: 2];
    wire [1:0] rx1_bits = sample_format_cfg[cffc_pkg::RX_FMT1_LSB +: 2];
    wire [1:0] tx2_bits = sample_format_cfg[cffc_pkg::TX_FMT2_LSB +: 2];
    wire [1:0] tx1_bits = sample_format_cfg[cffc_pkg::TX_FMT1_LSB +: 2];
    wire [1:0] src_bits = rx_source_cfg[cffc_pkg::RX_SRC_LSB +: 2];
    cffc_pkg::cffc_fmt_s next_fmt;
    assign next_fmt = cffc_pkg::cffc_fmt_s'({rx1_bits, rx2_bits, tx1_bits, tx2_bits, src_bits});

    // Output registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            afe_ctrl <= '0;
            fmt_ctrl <= '0;
        end else begin
            afe_ctrl <= next_afe;
            fmt_ctrl <= next_fmt;
        end
    end

    // Ringing pin synchroniser and speaker drive
    logic ring_meta;
    logic ring_sync;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_meta          <= 1'b0;
            ring_sync          <= 1'b0;
            speaker_drive_ring <= 1'b0;
            speaker_ring_level <= 1'b0;
        end else begin
            ring_meta          <= ring_square;
            ring_sync          <= ring_meta;
            speaker_drive_ring <= ring_spk;
            speaker_ring_level <= ring_spk && ring_sync;
        end
    end

    // Channel one voice bytes
    cffc_voice_split u_split (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .fmt            (cffc_pkg::cffc_fmt_e'(sample_format_cfg[cffc_pkg::TX_FMT1_LSB +: 2])),
        .sample         (tx_sample_ch1),
        .voice_reg_high (voice_reg_high),
        .voice_reg_low  (voice_reg_low)
    );

    AST_IN_GAIN_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_code == 4'h0) |=> !afe_ctrl.front_amp_on && !afe_ctrl.input_prefilter_on)
        else $error("input amplifier not powered down at code zero");

    AST_IN_GAIN_ON: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_code >= 4'h1 && in_code <= 4'h8) |=> afe_ctrl.front_amp_on &&
        afe_ctrl.input_gain_sel == $past(in_code))
        else $error("input gain code not applied");

    AST_BYPASS_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        (spk_code == 4'hf || ear_code == 4'hf || in_code == 4'hf) |=> afe_ctrl.bypass_test)
        else $error("bypass code did not raise test flag");

    AST_MON_FLOOR: assert property (@(posedge hclk) disable iff (!hresetn)
        (cmon_en && spk_code >= 4'h1 && spk_code <= 4'hc) |=>
        afe_ctrl.speaker_gain_sel == ($past(mon_floor) ? 4'hc : 4'h8))
        else $error("monitor floor level wrong");

    AST_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_src == 2'b11) |=> afe_ctrl.input_route == 3'b000)
        else $error("unused input source routed");

    AST_EAR_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (ear_code == 4'h0 || (ear_code > 4'h9 && ear_code < 4'hf)) |=> !afe_ctrl.earpiece_amp_on)
        else $error("earpiece not powered down");

    AST_SPK_RING_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ring_spk && (spk_code == 4'hd || spk_code == 4'he)) |=> !afe_ctrl.speaker_amp_on)
        else $error("ring-only speaker gain used without ringing");

    AST_FMT_FIELDS: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 fmt_ctrl.rx_fmt_ch2 == $past(sample_format_cfg[7:6]) &&
        fmt_ctrl.tx_fmt_ch1 == $past(sample_format_cfg[1:0]))
        else $error("format fields misplaced");

    AST_RX_SRC: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 fmt_ctrl.rx_src == $past(rx_source_cfg[7:6]))
        else $error("receive source field misplaced");

    AST_RING_DRIVE: assert property (@(posedge hclk) disable iff (!hresetn)
        !ring_spk |=> !speaker_ring_level && !speaker_drive_ring)
        else $error("speaker driven by ringing while disabled");

    // Undocumented input codes stay dark
    AST_IN_GAIN_BAD: assert property (
        (in_code > 4'h8 && in_code < 4'hf) |=>
        !afe_ctrl.front_amp_on && afe_ctrl.input_gain_sel == 4'h0)
        else $error("bad input code drove amplifier");

    // Used sources pick one route each
    AST_ROUTE_USED: assert property (
        (in_src != 2'b11) |=>
        afe_ctrl.input_route == (3'b001 << $past(in_src)))
        else $error("input route wrong");

    // Valid earpiece codes pass through
    AST_EAR_ON: assert property (
        (ear_code >= 4'h1 && ear_code <= 4'h9) |=>
        afe_ctrl.earpiece_amp_on && afe_ctrl.earpiece_gain_sel == $past(ear_code))
        else $error("earpiece code not applied");

    // Free speaker codes pass through
    AST_SPK_GAIN: assert property (
        (!cmon_en && spk_code >= 4'h1 && spk_code <= 4'hc) |=>
        afe_ctrl.speaker_amp_on && afe_ctrl.speaker_gain_sel == $past(spk_code))
        else $error("speaker code not applied");

    // Speaker code zero is off
    AST_SPK_OFF: assert property (
        (spk_code == 4'h0) |=>
        !afe_ctrl.speaker_amp_on && afe_ctrl.speaker_gain_sel == 4'h0)
        else $error("speaker not powered down");

    // Ring-only codes work while ringing
    AST_SPK_RING_GAIN: assert property (
        (ring_spk && (spk_code == 4'hd || spk_code == 4'he)) |=>
        afe_ctrl.speaker_amp_on && afe_ctrl.speaker_gain_sel == $past(spk_code))
        else $error("ring-only speaker code not applied");

    // Channel one receive and channel two transmit fields
    AST_FMT_LOW: assert property (
        ##1 fmt_ctrl.tx_fmt_ch2 == $past(sample_format_cfg[5:4]) &&
        fmt_ctrl.rx_fmt_ch1 == $past(sample_format_cfg[3:2]))
        else $error("inner format fields misplaced");

    // Receive front-end word stored whole
    AST_RX_KEEP: assert property (
        wr_rx |=>
        rx_frontend_cfg == $past(wdata))
        else $error("receive front-end write lost");

    // Transmit front-end codes kept as written
    AST_TX_KEEP: assert property (
        wr_tx |=>
        tx_frontend_cfg == $past(wdata))
        else $error("transmit front-end write altered");

    // Ringing reaches the speaker pins
    AST_RING_LEVEL: assert property (
        (ring_spk && ring_sync) |=>
        speaker_ring_level && speaker_drive_ring)
        else $error("ringing not driven to speaker");

    // Ring flag mirrors the control bit
    AST_RING_FLAG: assert property (
        ##1
        afe_ctrl.ring_to_speaker == $past(ring_spk))
        else $error("ring flag does not follow control bit");

    // Receive front-end reads back as stored
    AST_RD_RX: assert property (
        (dp_read && dp_index == cffc_pkg::RX_FRONTEND_IDX) |->
        hrdata == {24'h000000, rx_frontend_cfg})
        else $error("receive front-end read wrong");

endmodule : cffc_regs

// >>> design/cffc_voice_split.sv
`timescale 1ns/10ps
// Splits an internal 16-bit sample into high and low voice register bytes
module cffc_voice_split (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire cffc_pkg::cffc_fmt_e fmt,
    input  wire logic [15:0]         sample,
    output logic      [7:0]          voice_reg_high,
    output logic      [7:0]          voice_reg_low
);

    wire        is_linear = (fmt == cffc_pkg::CFFC_FMT_LIN8) || (fmt == cffc_pkg::CFFC_FMT_LIN16);
    wire        is_wide   = (fmt == cffc_pkg::CFFC_FMT_LIN16);
    wire [7:0]  next_high = is_linear ? sample[15:8] : sample[7:0];
    wire [7:0]  next_low  = is_wide ? sample[7:0] : 8'h00;

    // Byte registers; companded codes ride in the high byte of the word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            voice_reg_high <= 8'h00;
            voice_reg_low  <= 8'h00;
        end else begin
            voice_reg_high <= next_high;
            voice_reg_low  <= next_low;
        end
    end

    AST_LIN_HIGH_BYTE: assert property (@(posedge hclk) disable iff (!hresetn)
        is_linear |=> voice_reg_high == $past(sample[15:8]))
        else $error("linear high byte is not sample bits 15 to 8");

    AST_LIN16_LOW_BYTE: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wide |=> voice_reg_low == $past(sample[7:0]))
        else $error("16-bit low byte is not sample bits 7 to 0");

endmodule : cffc_voice_split

// >>> sim/cffc_regs_tb_top.sv
`timescale 1ns/10ps
module cffc_regs_tb_top;
    localparam logic [7:0] TXI = cffc_pkg::TX_FRONTEND_IDX;
    localparam logic [7:0] RXI = cffc_pkg::RX_FRONTEND_IDX;
    localparam logic [7:0] FMI = cffc_pkg::SAMPLE_FORMAT_IDX;
    localparam logic [7:0] SRI = cffc_pkg::RX_SOURCE_IDX;
    localparam logic [7:0] MSI = cffc_pkg::MISC_CTRL_IDX;
    logic                hclk;
    logic                hresetn;
    logic                hsel;
    logic [31:0]         haddr;
    logic [1:0]          htrans;
    logic                hwrite;
    logic [2:0]          hsize;
    logic [31:0]         hwdata;
    wire logic           hready;
    logic [31:0]         hrdata;
    logic                hreadyout;
    logic                hresp;
    logic [15:0]         tx_sample_ch1;
    logic                ring_square;
    cffc_pkg::cffc_afe_s afe_ctrl;
    cffc_pkg::cffc_fmt_s fmt_ctrl;
    logic                speaker_drive_ring;
    logic                speaker_ring_level;
    int                  n_errors = 0;
    int                  checks = 0;
    int                  cycles = 0;
    logic [31:0]         rd;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    cffc_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .tx_sample_ch1(tx_sample_ch1),
        .ring_square(ring_square), .afe_ctrl(afe_ctrl), .fmt_ctrl(fmt_ctrl),
        .speaker_drive_ring(speaker_drive_ring), .speaker_ring_level(speaker_ring_level));

    // Clock source
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test;
        end
    end

    task automatic chk_rd(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_rd

    task automatic chk_out(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_out

    // One single AHB-Lite transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdat);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdat = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, {24'h0, d}, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0, rd);
        chk_rd("read data", exp, rd);
    endtask : rd_chk

    // Let the stored value reach the control outputs
    task automatic settle;
        repeat (2) @(posedge hclk);
    endtask : settle

    task automatic t_reset;
        chk_rd("afe_ctrl", 32'h0, {11'h0, afe_ctrl});
        chk_rd("fmt_ctrl", 32'h0, {22'h0, fmt_ctrl});
        chk_out("hreadyout", 8'h01, {7'h00, hreadyout});
        chk_out("hresp", 8'h00, {7'h00, hresp});
        rd_chk(TXI, 32'h0);
        rd_chk(RXI, 32'h0);
        rd_chk(FMI, 32'h0);
        rd_chk(SRI, 32'h0);
        rd_chk(MSI, 32'h0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_input;
        logic       on;
        logic [2:0] rt [4];
        rt = '{3'h1, 3'h2, 3'h4, 3'h0};
        for (int c = 0; c < 16; c++) begin
            on = (c >= 1 && c <= 8) || c == 15;
            wr(TXI, {c[3:0], 4'h0});
            settle;
            chk_out("front_amp_on", {7'h0, on}, {7'h0, afe_ctrl.front_amp_on});
            chk_out("prefilter_on", {7'h0, on}, {7'h0, afe_ctrl.input_prefilter_on});
            chk_out("bypass_test", {7'h0, c == 15}, {7'h0, afe_ctrl.bypass_test});
            if (on && c != 15) chk_out("in_gain", 8'(c), {4'h0, afe_ctrl.input_gain_sel});
            rd_chk(TXI, 32'(c * 16));
        end
        for (int s = 0; s < 4; s++) begin
            wr(TXI, 8'(s));
            settle;
            chk_out("input_route", {5'h0, rt[s]}, {5'h0, afe_ctrl.input_route});
        end
        $display("t_input done");
    endtask : t_input

    task automatic t_rx_gain;
        logic ear;
        logic spk;
        for (int c = 0; c < 16; c++) begin
            ear = (c >= 1 && c <= 9) || c == 15;
            spk = (c >= 1 && c <= 12) || c == 15;
            wr(RXI, {c[3:0], c[3:0]});
            settle;
            chk_out("ear_on", {7'h0, ear}, {7'h0, afe_ctrl.earpiece_amp_on});
            if (ear && c != 15) chk_out("ear", 8'(c), {4'h0, afe_ctrl.earpiece_gain_sel});
            chk_out("spk_on", {7'h0, spk}, {7'h0, afe_ctrl.speaker_amp_on});
            chk_out("bypass_test", {7'h0, c == 15}, {7'h0, afe_ctrl.bypass_test});
            if (spk && c != 15) chk_out("spk", 8'(c), {4'h0, afe_ctrl.speaker_gain_sel});
            rd_chk(RXI, 32'(c * 17));
        end
        wr(MSI, 8'h02);
        for (int c = 13; c < 15; c++) begin
            wr(RXI, 8'(c));
            settle;
            chk_out("spk_on", 8'h1, {7'h0, afe_ctrl.speaker_amp_on});
            chk_out("spk", 8'(c), {4'h0, afe_ctrl.speaker_gain_sel});
        end
        chk_out("drive_ring", 8'h1, {7'h0, speaker_drive_ring});
        chk_out("ring_flag", 8'h1, {7'h0, afe_ctrl.ring_to_speaker});
        ring_square <= 1'b1;
        repeat (5) @(posedge hclk);
        chk_out("ring_level", 8'h1, {7'h0, speaker_ring_level});
        ring_square <= 1'b0;
        repeat (5) @(posedge hclk);
        chk_out("ring_level", 8'h0, {7'h0, speaker_ring_level});
        wr(MSI, 8'h00);
        settle;
        chk_out("drive_ring", 8'h0, {7'h0, speaker_drive_ring});
        chk_out("ring_flag", 8'h0, {7'h0, afe_ctrl.ring_to_speaker});
        $display("t_rx_gain done");
    endtask : t_rx_gain

    task automatic t_monitor;
        wr(MSI, 8'h01);
        wr(RXI, 8'h03);
        for (int f = 0; f < 2; f++) begin
            wr(TXI, 8'(f * 4));
            settle;
            chk_out("floor", f ? 8'h0c : 8'h08, {4'h0, afe_ctrl.speaker_gain_sel});
        end
        wr(MSI, 8'h00);
        settle;
        chk_out("spk free", 8'h03, {4'h0, afe_ctrl.speaker_gain_sel});
        $display("t_monitor done");
    endtask : t_monitor

    task automatic t_format;
        logic [7:0] p [2];
        p = '{8'he4, 8'h1b};
        foreach (p[i]) begin
            wr(FMI, p[i]);
            settle;
            chk_out("rx2", {6'h0, p[i][7:6]}, {6'h0, fmt_ctrl.rx_fmt_ch2});
            chk_out("tx2", {6'h0, p[i][5:4]}, {6'h0, fmt_ctrl.tx_fmt_ch2});
            chk_out("rx1", {6'h0, p[i][3:2]}, {6'h0, fmt_ctrl.rx_fmt_ch1});
            chk_out("tx1", {6'h0, p[i][1:0]}, {6'h0, fmt_ctrl.tx_fmt_ch1});
            rd_chk(FMI, {24'h0, p[i]});
        end
        for (int s = 0; s < 4; s++) begin
            wr(SRI, 8'(s * 64));
            settle;
            chk_out("rx_src", 8'(s), {6'h0, fmt_ctrl.rx_src});
        end
        $display("t_format done");
    endtask : t_format

    task automatic t_voice;
        tx_sample_ch1 <= 16'ha5c3;
        wr(FMI, 8'h03);
        settle;
        bus(1'b0, cffc_pkg::VOICE_DATA_IDX, 32'h0, rd);
        chk_rd("voice lin16", 32'h0000a5c3, rd);
        wr(FMI, 8'h02);
        settle;
        bus(1'b0, cffc_pkg::VOICE_DATA_IDX, 32'h0, rd);
        chk_out("voice lin8", 8'ha5, rd[15:8]);
        wr(FMI, 8'h00);
        settle;
        bus(1'b0, cffc_pkg::VOICE_DATA_IDX, 32'h0, rd);
        chk_out("voice alaw", 8'hc3, rd[15:8]);
        wr(8'h7f, 8'hff);
        rd_chk(8'h7f, 32'h0);
        $display("t_voice done");
    endtask : t_voice

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tx_sample_ch1 = 16'h0;
        ring_square = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_input;
        t_rx_gain;
        t_monitor;
        t_format;
        t_voice;
        end_of_test;
    end
endmodule : cffc_regs_tb_top
